// ==== bench/lpwg_src_model.sv ====
// event source model: pending lines and reset events for the wake block
// assumes the bench sets i_sel and i_lag before raising i_fire
`timescale 1ns/1ps

module lpwg_src_model (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_fire,
    input wire logic [4:0] i_sel,
    input wire logic [1:0] i_lag,
    output logic [31:0] o_irq_pend,
    output logic o_brownout_rst,
    output logic o_wdog_rst
);
    logic [3:0] fire_reg;
    logic on;
    assign on = fire_reg[i_lag];
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fire_reg <= 4'h0;
            o_irq_pend <= 32'h0;
            o_brownout_rst <= 1'b0;
            o_wdog_rst <= 1'b0;
        end else begin
            fire_reg <= {fire_reg[2:0], i_fire};
            o_irq_pend <= (on && i_sel < 5'h10) ? 32'h1 << i_sel : 32'h0;
            o_brownout_rst <= on && i_sel == 5'h10;
            o_wdog_rst <= on && i_sel == 5'h11;
        end
    end
endmodule : lpwg_src_model

// ==== bench/lpwg_top_properties.sv ====
// port-level checker for lpwg_top, bound into every instance
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/1ps
`include "lpwg_params.svh"

module lpwg_props (
    input wire logic I_CLK_SYS,
    input wire logic I_ARST_N,
    input wire logic I_ENTER,
    input wire logic [2:0] I_MODE_REQ,
    input wire logic [`LPWG_NIRQ-1:0] I_IRQ_PEND,
    input wire logic [`LPWG_NIRQ-1:0] I_IRQ_EN,
    input wire logic [`LPWG_NIRQ-1:0] I_WAKE_EN0,
    input wire logic [`LPWG_NIRQ-1:0] I_WAKE_EN1,
    input wire logic I_RESET_PIN_N,
    input wire logic [2:0] O_MODE,
    input wire logic O_WAKE,
    input wire logic [3:0] O_WAKE_CAUSE,
    input wire logic O_RESET_REQ,
    input wire logic O_CORE_CLK_EN,
    input wire logic O_PERIPH_CLK_EN
);
    logic [`LPWG_NIRQ-1:0] ie_c;
    logic [`LPWG_NIRQ-1:0] we_c;
    // enables as captured at mode entry
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ie_c <= '0;
            we_c <= '0;
        end else if (O_MODE == 3'h0) begin
            ie_c <= I_IRQ_EN;
            we_c <= I_WAKE_EN0 | I_WAKE_EN1;
        end
    end
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_ARST_N);
    AST_WAKE_ACTIVE: assert property (
        O_WAKE |-> O_MODE == 3'h0 && O_CORE_CLK_EN) else $error("wake bad");
    AST_WAKE_PULSE: assert property (
        O_WAKE |=> !O_WAKE) else $error("wake too long");
    AST_CLK_EN: assert property (
        O_CORE_CLK_EN == (O_MODE == 3'h0)
        && O_PERIPH_CLK_EN == (O_MODE <= 3'h1)) else $error("clock enable");
    AST_WAKE_SRC: assert property (
        O_WAKE |-> $past(O_MODE) != 3'h0) else $error("wake from active");
    AST_ENTRY: assert property (
        O_MODE == 3'h0 && !O_WAKE && I_ENTER
        && I_MODE_REQ inside {[3'h1:3'h4]} && I_RESET_PIN_N
        && $past(I_RESET_PIN_N) && $past(I_RESET_PIN_N, 2)
        |=> O_MODE == $past(I_MODE_REQ)) else $error("entry lost");
    AST_REFUSE: assert property (
        O_MODE == 3'h0 && !(I_ENTER && I_MODE_REQ inside {[3'h1:3'h4]})
        |=> O_MODE == 3'h0) else $error("bad entry taken");
    AST_CAUSE_HOLD: assert property (
        !O_WAKE |-> $stable(O_WAKE_CAUSE)) else $error("cause moved");
    AST_SLEEP_IRQ: assert property (
        O_MODE == 3'h1 && |(I_IRQ_PEND & ie_c)
        |=> O_WAKE && O_WAKE_CAUSE inside {4'h1, 4'h4}) else $error("sleep");
    AST_PIN_WAKE: assert property (
        O_MODE inside {3'h2, 3'h3}
        && |(I_IRQ_PEND[7:0] & ie_c[7:0] & we_c[7:0])
        |=> O_WAKE && O_WAKE_CAUSE <= 4'h5) else $error("pin wake");
    AST_DPD_REBOOT: assert property (
        O_WAKE && $past(O_MODE) == 3'h4 |-> O_RESET_REQ)
        else $error("reboot");
    AST_RESET_PIN: assert property (
        (O_MODE != 3'h0 && !I_RESET_PIN_N) [*3]
        |=> O_WAKE && O_WAKE_CAUSE == 4'h1) else $error("reset pin");
    cover property (O_WAKE && O_WAKE_CAUSE == 4'h4);
    cover property (O_WAKE && O_WAKE_CAUSE == 4'h5);
    cover property (O_WAKE && O_WAKE_CAUSE == 4'h1);
    cover property (O_WAKE && $past(O_MODE) == 3'h4);
endmodule : lpwg_props

bind lpwg_top lpwg_props i_props (
    .I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .I_ENTER(I_ENTER),
    .I_MODE_REQ(I_MODE_REQ), .I_IRQ_PEND(I_IRQ_PEND), .I_IRQ_EN(I_IRQ_EN),
    .I_WAKE_EN0(I_WAKE_EN0), .I_WAKE_EN1(I_WAKE_EN1),
    .I_RESET_PIN_N(I_RESET_PIN_N), .O_MODE(O_MODE), .O_WAKE(O_WAKE),
    .O_WAKE_CAUSE(O_WAKE_CAUSE), .O_RESET_REQ(O_RESET_REQ),
    .O_CORE_CLK_EN(O_CORE_CLK_EN), .O_PERIPH_CLK_EN(O_PERIPH_CLK_EN)
);

// ==== bench/testbench.sv ====
// self-checking bench: random mode entry, config and one wake event
// assumes lpwg_top, the source model and the bound checker
`timescale 1ns/1ps
`include "lpwg_params.svh"

module testbench;
    import lpwg_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic enter = 1'b0;
    logic [2:0] mode_req = 3'h0;
    logic [31:0] ie = 32'h0;
    logic [31:0] w0 = 32'h0;
    logic [31:0] w1 = 32'h0;
    logic [21:0] f = 22'h0;
    logic pin_n = 1'b1;
    logic evt_on = 1'b0;
    logic [4:0] evt_sel = 5'h0;
    logic [1:0] lag = 2'h0;
    logic seen;
    logic [31:0] pend;
    logic bo_rst, wd_rst, wake, rreq, cclk, pclk;
    logic [2:0] mode;
    logic [3:0] cause;
    int failures = 0;
    int cmp_count = 0;
    int seed = 74817;

    always #10 clk = ~clk;

    lpwg_top i_dut (
        .I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_ENTER(enter),
        .I_MODE_REQ(mode_req), .I_IRQ_PEND(pend), .I_IRQ_EN(ie),
        .I_WAKE_EN0(w0), .I_WAKE_EN1(w1), .I_BROWNOUT_IRQ_EN(f[0]),
        .I_BROWNOUT_RST_EN(f[1]), .I_BROWNOUT_KEEP_ON(f[2]),
        .I_BROWNOUT_RST(bo_rst), .I_WDOG_OSC_POWERED(f[3]),
        .I_WDOG_OSC_KEEP_ON(f[4]), .I_WDOG_EN(f[5]), .I_WDOG_IRQ_EN(f[6]),
        .I_WDOG_RST_EN(f[7]), .I_WDOG_FED(f[8]), .I_WDOG_RST(wd_rst),
        .I_RTC_OSC_1HZ_EN(f[9]), .I_RTC_OSC_1KHZ_EN(f[10]),
        .I_RTC_CTRL_1HZ_EN(f[11]), .I_RTC_CTRL_1KHZ_EN(f[12]),
        .I_RTC_BUS_CLK_EN(f[13]), .I_RTC_ALARM_ARMED(f[14]),
        .I_RTC_FAST_ARMED(f[15]), .I_MICROTICK_CLK_EN(f[16]),
        .I_MICROTICK_STARTED(f[17]), .I_I2C_SLAVE(f[18]),
        .I_SPI_SLAVE(f[19]), .I_USART_SLAVE(f[20]), .I_USART_32K(f[21]),
        .I_RESET_PIN_N(pin_n), .O_MODE(mode), .O_WAKE(wake),
        .O_WAKE_CAUSE(cause), .O_RESET_REQ(rreq), .O_CORE_CLK_EN(cclk),
        .O_PERIPH_CLK_EN(pclk)
    );

    lpwg_src_model i_src (
        .i_clk(clk), .i_arst_n(arst_n), .i_fire(evt_on), .i_sel(evt_sel),
        .i_lag(lag), .o_irq_pend(pend), .o_brownout_rst(bo_rst),
        .o_wdog_rst(wd_rst)
    );

    // expected wake cause for one event under the captured setup
    function automatic logic [3:0] exp_cause(input logic [2:0] m,
        input logic [21:0] c, input logic [31:0] e, input logic [31:0] a,
        input logic [31:0] b, input logic [4:0] s);
        if (m == 3'h1) return (s < 5'h10 && e[s]) ? 4'h4 : 4'h0;
        if (m == 3'h4) begin
            if (s == 5'hA && c[11] && c[14]) return 4'h8;
            if (s == 5'hB && c[9] && c[10] && c[13] && c[15]) return 4'h9;
            return 4'h0;
        end
        if (s < 5'h8) return (e[s] && (a[s] || b[s])) ? 4'h5 : 4'h0;
        case (s)
            5'h08: return (e[8] && a[8] && c[0] && c[2]) ? 4'h6 : 4'h0;
            5'h09: return (&c[6:3] && c[8] && e[9] && a[9]) ? 4'h7 : 4'h0;
            5'h0A: return (c[9] && c[13] && c[14] && a[10]) ? 4'h8 : 4'h0;
            5'h0B: return (c[11] && c[12] && c[15] && a[11]) ? 4'h9 : 4'h0;
            5'h0C: return (c[3] && c[16] && c[17] && a[12]) ? 4'hA : 4'h0;
            5'h0D: return c[18] ? 4'hB : 4'h0;
            5'h0E: return c[19] ? 4'hC : 4'h0;
            5'h0F: return (c[20] || c[21]) ? 4'hD : 4'h0;
            5'h10: return c[1] ? 4'h2 : 4'h0;
            5'h11: return (c[3] && c[5] && c[7] && c[8]) ? 4'h3 : 4'h0;
            default: return 4'h0;
        endcase
    endfunction : exp_cause

    task automatic chk_val(input logic [3:0] got, input logic [3:0] exp,
        input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_val

    task automatic chk_flag(input logic got, input logic exp,
        input string what);
        chk_val({3'h0, got}, {3'h0, exp}, what);
    endtask : chk_flag

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    task automatic rnd_cfg;
        ie = $random(seed) | $random(seed);
        w0 = $random(seed) | $random(seed);
        w1 = $random(seed) & $random(seed);
        f = 22'($random(seed) | $random(seed));
    endtask : rnd_cfg

    task automatic do_enter(input logic [2:0] m);
        enter = 1'b1;
        mode_req = m;
        tick();
        enter = 1'b0;
        mode_req = 3'h0;
    endtask : do_enter

    task automatic wait_wake(input int n);
        seen = 1'b0;
        for (int i = 0; i < n && !seen; i++) begin
            tick();
            seen = (wake === 1'b1);
        end
    endtask : wait_wake

    task automatic end_of_test;
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #600000;
        failures++;
        end_of_test();
    end

    initial begin
        logic [2:0] bad [4];
        logic [2:0] m;
        logic [3:0] ec;
        bad = '{3'h0, 3'h5, 3'h6, 3'h7};
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        tick();
        tick();
        chk_val({1'b0, mode}, 4'h0, "reset mode");
        chk_flag(cclk && pclk, 1'b1, "reset clocks");
        foreach (bad[k]) begin
            do_enter(bad[k]);
            chk_val({1'b0, mode}, 4'h0, "refused code");
            tick();
        end
        pin_n = 1'b0;
        repeat (3) tick();
        chk_flag(rreq, 1'b1, "pin reset req");
        do_enter(3'h2);
        chk_val({1'b0, mode}, 4'h0, "entry in reset");
        pin_n = 1'b1;
        repeat (4) tick();
        for (int t = 0; t < 200; t++) begin
            m = 3'(1 + ($unsigned($random(seed)) % 4));
            rnd_cfg();
            do_enter(m);
            chk_val({1'b0, mode}, {1'b0, m}, "entered");
            chk_flag(pclk, m == 3'h1, "periph clock");
            chk_flag(cclk, 1'b0, "core clock");
            evt_sel = 5'($unsigned($random(seed)) % 18);
            lag = 2'($random(seed));
            ec = exp_cause(m, f, ie, w0, w1, evt_sel);
            if (t % 2) rnd_cfg();
            evt_on = 1'b1;
            wait_wake(8);
            chk_flag(seen, ec != 4'h0, "qualified wake");
            if (ec == 4'h0) begin
                pin_n = 1'b0;
                wait_wake(6);
                ec = 4'h1;
            end
            chk_val(cause, ec, "cause");
            chk_val({1'b0, mode}, 4'h0, "resume mode");
            chk_flag(cclk && pclk, 1'b1, "resume clocks");
            chk_flag(rreq, ec < 4'h4 || m == 3'h4, "rreq");
            evt_on = 1'b0;
            pin_n = 1'b1;
            repeat (6) tick();
        end
        end_of_test();
    end
endmodule : testbench

// ==== hdl/lpwg_params.svh ====
// constants for the low power wake-up gating block
// assumes inclusion by the package, the modules of this block and the bench files
`ifndef LPWG_PARAMS_SVH
`define LPWG_PARAMS_SVH

// width of the interrupt pending and enable vectors
`define LPWG_NIRQ 32
// number of pin interrupts, placed from line zero upward
`define LPWG_NPIN 8
`define LPWG_IRQ_PIN0 0
// interrupt line of each on-chip source, also its wake enable bit for lines 8 to 12
`define LPWG_IRQ_BROWNOUT 8
`define LPWG_IRQ_WDOG 9
`define LPWG_IRQ_RTC_ALARM 10
`define LPWG_IRQ_RTC_FAST 11
`define LPWG_IRQ_MICROTICK 12
`define LPWG_IRQ_I2C 13
`define LPWG_IRQ_SPI 14
`define LPWG_IRQ_USART 15
// number of wake cause codes, code zero meaning none
`define LPWG_NCAUSE 14
// reset level of the synchronised reset pin (pin released)
`define LPWG_PIN_RST_VAL 1'b1

`endif

// ==== hdl/lpwg_pin_wake.sv ====
// wake qualifier for one pin interrupt in deep-sleep and power-down
// assumes all inputs come from logic on the system clock
`timescale 1ns/1ps

module lpwg_pin_wake
    import lpwg_pkg::*;
(
    input wire logic i_pend,
    input wire logic i_irq_en,
    input wire logic i_wake_en0,
    input wire logic i_wake_en1,
    output logic o_wake
);

    assign o_wake = i_pend & i_irq_en & (i_wake_en0 | i_wake_en1);

endmodule : lpwg_pin_wake

// ==== hdl/lpwg_pkg.sv ====
// types shared by the low power wake-up gating modules
// assumes lpwg_params.svh is on the include path
`include "lpwg_params.svh"

package lpwg_pkg;

    typedef enum logic [2:0] {
        LPWG_ACTIVE = 3'b000,
        LPWG_SLEEP = 3'b001,
        LPWG_DEEP_SLEEP = 3'b010,
        LPWG_POWER_DOWN = 3'b011,
        LPWG_DEEP_PD = 3'b100
    } lpwg_mode_type;

    typedef enum logic [3:0] {
        LPWG_CAUSE_NONE = 4'b0000,
        LPWG_CAUSE_RESET_PIN = 4'b0001,
        LPWG_CAUSE_BROWNOUT_RST = 4'b0010,
        LPWG_CAUSE_WDOG_RST = 4'b0011,
        LPWG_CAUSE_IRQ = 4'b0100,
        LPWG_CAUSE_PIN = 4'b0101,
        LPWG_CAUSE_BROWNOUT_IRQ = 4'b0110,
        LPWG_CAUSE_WDOG_IRQ = 4'b0111,
        LPWG_CAUSE_RTC_ALARM = 4'b1000,
        LPWG_CAUSE_RTC_FAST = 4'b1001,
        LPWG_CAUSE_MICROTICK = 4'b1010,
        LPWG_CAUSE_I2C = 4'b1011,
        LPWG_CAUSE_SPI = 4'b1100,
        LPWG_CAUSE_USART = 4'b1101
    } lpwg_cause_type;

    // wake configuration captured when a reduced mode is entered
    typedef struct packed {
        logic [`LPWG_NIRQ-1:0] irq_en;
        logic [`LPWG_NIRQ-1:0] wake_en0;
        logic [`LPWG_NIRQ-1:0] wake_en1;
        logic brownout_irq_en;
        logic brownout_rst_en;
        logic brownout_keep_on;
        logic wdog_osc_powered;
        logic wdog_osc_keep_on;
        logic wdog_en;
        logic wdog_irq_en;
        logic wdog_rst_en;
        logic wdog_fed;
        logic rtc_osc_1hz_en;
        logic rtc_osc_1khz_en;
        logic rtc_ctrl_1hz_en;
        logic rtc_ctrl_1khz_en;
        logic rtc_bus_clk_en;
        logic rtc_alarm_armed;
        logic rtc_fast_armed;
        logic microtick_clk_en;
        logic microtick_started;
        logic i2c_slave;
        logic spi_slave;
        logic usart_slave;
        logic usart_32k;
    } lpwg_cfg_type;

    typedef struct packed {
        lpwg_mode_type mode;
        lpwg_cfg_type cfg;
        logic wake;
        lpwg_cause_type cause;
        logic reset_req;
        logic pin_act_prev;
        logic core_clk_en;
        logic periph_clk_en;
    } lpwg_state_type;

    typedef struct packed {
        logic meta;
        logic q;
    } lpwg_sync_state_type;

endpackage : lpwg_pkg

// ==== hdl/lpwg_sync.sv ====
// two flip-flop synchroniser for one level from outside the clock domain
// assumes the input is a slow level such as a reset pin
`timescale 1ns/1ps

module lpwg_sync
    import lpwg_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_d,
    output logic o_q
);

    lpwg_sync_state_type s_reg;
    lpwg_sync_state_type s_next;

    always_comb begin
        s_next.meta = i_d;
        s_next.q = s_reg.meta;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_reg.meta <= RST_VAL;
            s_reg.q <= RST_VAL;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_q = s_reg.q;

endmodule : lpwg_sync

// ==== hdl/lpwg_top.sv ====
// low power wake-up gating: mode entry, wake qualification, resume
// assumes core, interrupt controller and event sources share I_CLK_SYS;
// only the external reset pin is asynchronous
//
// Overview of operation
// - every wake from a reduced mode returns the part to active mode.
// - only sources allowed in the mode end it, each set up before entry.
// - in sleep any interrupt enabled in the controller wakes the processor.
// - in deep modes a pin interrupt needs controller and wake enables.
// - a brownout interrupt needs three enables and the detector kept on.
// - a brownout reset ends deep-sleep or power-down if reset is enabled.
// - a watchdog interrupt needs oscillator on and kept, enables, fed.
// - a watchdog reset needs oscillator on, watchdog and reset enabled, fed.
// - the 1 Hz alarm needs oscillator, bus clock, armed count and wake enable.
// - the 1 kHz timer needs both rtc control enables, count, wake enable.
// - the micro-tick timer needs oscillator, clock, start and wake enable.
// - an I2C slave interrupt wakes deep-sleep or power-down.
// - an SPI slave interrupt wakes deep-sleep or power-down.
// - a USART interrupt in slave or 32 kHz mode wakes the deep modes.
// - in deep power-down the 1 Hz alarm needs rtc control enable, count.
// - in deep power-down the 1 kHz timer needs oscillators, clock, count.
`timescale 1ns/1ps
`include "lpwg_params.svh"

module lpwg_top
    import lpwg_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_ARST_N,
    input wire logic I_ENTER,
    input wire logic [2:0] I_MODE_REQ,
    input wire logic [`LPWG_NIRQ-1:0] I_IRQ_PEND,
    input wire logic [`LPWG_NIRQ-1:0] I_IRQ_EN,
    input wire logic [`LPWG_NIRQ-1:0] I_WAKE_EN0,
    input wire logic [`LPWG_NIRQ-1:0] I_WAKE_EN1,
    input wire logic I_BROWNOUT_IRQ_EN,
    input wire logic I_BROWNOUT_RST_EN,
    input wire logic I_BROWNOUT_KEEP_ON,
    input wire logic I_BROWNOUT_RST,
    input wire logic I_WDOG_OSC_POWERED,
    input wire logic I_WDOG_OSC_KEEP_ON,
    input wire logic I_WDOG_EN,
    input wire logic I_WDOG_IRQ_EN,
    input wire logic I_WDOG_RST_EN,
    input wire logic I_WDOG_FED,
    input wire logic I_WDOG_RST,
    input wire logic I_RTC_OSC_1HZ_EN,
    input wire logic I_RTC_OSC_1KHZ_EN,
    input wire logic I_RTC_CTRL_1HZ_EN,
    input wire logic I_RTC_CTRL_1KHZ_EN,
    input wire logic I_RTC_BUS_CLK_EN,
    input wire logic I_RTC_ALARM_ARMED,
    input wire logic I_RTC_FAST_ARMED,
    input wire logic I_MICROTICK_CLK_EN,
    input wire logic I_MICROTICK_STARTED,
    input wire logic I_I2C_SLAVE,
    input wire logic I_SPI_SLAVE,
    input wire logic I_USART_SLAVE,
    input wire logic I_USART_32K,
    input wire logic I_RESET_PIN_N,
    output logic [2:0] O_MODE,
    output logic O_WAKE,
    output logic [3:0] O_WAKE_CAUSE,
    output logic O_RESET_REQ,
    output logic O_CORE_CLK_EN,
    output logic O_PERIPH_CLK_EN
);

    lpwg_state_type state_reg;
    lpwg_state_type state_next;
    lpwg_cfg_type cfg_in;
    logic pin_sync;
    logic pin_act;
    logic [`LPWG_NPIN-1:0] pin_wake;
    logic [`LPWG_NCAUSE-1:0] src;
    logic deep_mode;
    logic dpd_mode;
    logic req_ok;
    lpwg_cause_type cause_sel;

    // reset pin synchroniser
    lpwg_sync #(
        .RST_VAL(`LPWG_PIN_RST_VAL)
    ) u_pin_sync (
        .i_clk(I_CLK_SYS),
        .i_arst_n(I_ARST_N),
        .i_d(I_RESET_PIN_N),
        .o_q(pin_sync)
    );

    assign pin_act = ~pin_sync;

    // gather the live configuration for capture at entry
    always_comb begin
        cfg_in.irq_en = I_IRQ_EN;
        cfg_in.wake_en0 = I_WAKE_EN0;
        cfg_in.wake_en1 = I_WAKE_EN1;
        cfg_in.brownout_irq_en = I_BROWNOUT_IRQ_EN;
        cfg_in.brownout_rst_en = I_BROWNOUT_RST_EN;
        cfg_in.brownout_keep_on = I_BROWNOUT_KEEP_ON;
        cfg_in.wdog_osc_powered = I_WDOG_OSC_POWERED;
        cfg_in.wdog_osc_keep_on = I_WDOG_OSC_KEEP_ON;
        cfg_in.wdog_en = I_WDOG_EN;
        cfg_in.wdog_irq_en = I_WDOG_IRQ_EN;
        cfg_in.wdog_rst_en = I_WDOG_RST_EN;
        cfg_in.wdog_fed = I_WDOG_FED;
        cfg_in.rtc_osc_1hz_en = I_RTC_OSC_1HZ_EN;
        cfg_in.rtc_osc_1khz_en = I_RTC_OSC_1KHZ_EN;
        cfg_in.rtc_ctrl_1hz_en = I_RTC_CTRL_1HZ_EN;
        cfg_in.rtc_ctrl_1khz_en = I_RTC_CTRL_1KHZ_EN;
        cfg_in.rtc_bus_clk_en = I_RTC_BUS_CLK_EN;
        cfg_in.rtc_alarm_armed = I_RTC_ALARM_ARMED;
        cfg_in.rtc_fast_armed = I_RTC_FAST_ARMED;
        cfg_in.microtick_clk_en = I_MICROTICK_CLK_EN;
        cfg_in.microtick_started = I_MICROTICK_STARTED;
        cfg_in.i2c_slave = I_I2C_SLAVE;
        cfg_in.spi_slave = I_SPI_SLAVE;
        cfg_in.usart_slave = I_USART_SLAVE;
        cfg_in.usart_32k = I_USART_32K;
    end

    // per pin interrupt qualification
    genvar gi;
    generate
        for (gi = 0; gi < `LPWG_NPIN; gi = gi + 1) begin : g_pin
            lpwg_pin_wake u_pin_wake (
                .i_pend(I_IRQ_PEND[`LPWG_IRQ_PIN0 + gi]),
                .i_irq_en(state_reg.cfg.irq_en[`LPWG_IRQ_PIN0 + gi]),
                .i_wake_en0(state_reg.cfg.wake_en0[`LPWG_IRQ_PIN0 + gi]),
                .i_wake_en1(state_reg.cfg.wake_en1[`LPWG_IRQ_PIN0 + gi]),
                .o_wake(pin_wake[gi])
            );
        end
    endgenerate

    assign deep_mode = (state_reg.mode == LPWG_DEEP_SLEEP) ||
                       (state_reg.mode == LPWG_POWER_DOWN);
    assign dpd_mode = (state_reg.mode == LPWG_DEEP_PD);

    // wake source vector, indexed by cause code
    always_comb begin
        src = '0;
        src[LPWG_CAUSE_RESET_PIN] = pin_act &&
                                    (state_reg.mode != LPWG_ACTIVE);
        src[LPWG_CAUSE_IRQ] = (state_reg.mode == LPWG_SLEEP) &&
            ((I_IRQ_PEND & state_reg.cfg.irq_en) != '0);
        src[LPWG_CAUSE_PIN] = deep_mode && (pin_wake != '0);
        src[LPWG_CAUSE_BROWNOUT_IRQ] = deep_mode &&
            I_IRQ_PEND[`LPWG_IRQ_BROWNOUT] &&
            state_reg.cfg.irq_en[`LPWG_IRQ_BROWNOUT] &&
            state_reg.cfg.wake_en0[`LPWG_IRQ_BROWNOUT] &&
            state_reg.cfg.brownout_irq_en &&
            state_reg.cfg.brownout_keep_on;
        src[LPWG_CAUSE_BROWNOUT_RST] = deep_mode && I_BROWNOUT_RST &&
            state_reg.cfg.brownout_rst_en;
        src[LPWG_CAUSE_WDOG_IRQ] = deep_mode &&
            I_IRQ_PEND[`LPWG_IRQ_WDOG] &&
            state_reg.cfg.wdog_osc_powered &&
            state_reg.cfg.wdog_osc_keep_on &&
            state_reg.cfg.irq_en[`LPWG_IRQ_WDOG] &&
            state_reg.cfg.wake_en0[`LPWG_IRQ_WDOG] &&
            state_reg.cfg.wdog_en &&
            state_reg.cfg.wdog_irq_en &&
            state_reg.cfg.wdog_fed;
        src[LPWG_CAUSE_WDOG_RST] = deep_mode && I_WDOG_RST &&
            state_reg.cfg.wdog_osc_powered &&
            state_reg.cfg.wdog_en &&
            state_reg.cfg.wdog_rst_en &&
            state_reg.cfg.wdog_fed;
        if (deep_mode) begin
            src[LPWG_CAUSE_RTC_ALARM] =
                I_IRQ_PEND[`LPWG_IRQ_RTC_ALARM] &&
                state_reg.cfg.rtc_osc_1hz_en &&
                state_reg.cfg.rtc_bus_clk_en &&
                state_reg.cfg.rtc_alarm_armed &&
                state_reg.cfg.wake_en0[`LPWG_IRQ_RTC_ALARM];
            src[LPWG_CAUSE_RTC_FAST] =
                I_IRQ_PEND[`LPWG_IRQ_RTC_FAST] &&
                state_reg.cfg.rtc_ctrl_1hz_en &&
                state_reg.cfg.rtc_ctrl_1khz_en &&
                state_reg.cfg.rtc_fast_armed &&
                state_reg.cfg.wake_en0[`LPWG_IRQ_RTC_FAST];
        end else if (dpd_mode) begin
            src[LPWG_CAUSE_RTC_ALARM] =
                I_IRQ_PEND[`LPWG_IRQ_RTC_ALARM] &&
                state_reg.cfg.rtc_ctrl_1hz_en &&
                state_reg.cfg.rtc_alarm_armed;
            src[LPWG_CAUSE_RTC_FAST] =
                I_IRQ_PEND[`LPWG_IRQ_RTC_FAST] &&
                state_reg.cfg.rtc_osc_1hz_en &&
                state_reg.cfg.rtc_osc_1khz_en &&
                state_reg.cfg.rtc_bus_clk_en &&
                state_reg.cfg.rtc_fast_armed;
        end
        src[LPWG_CAUSE_MICROTICK] = deep_mode &&
            I_IRQ_PEND[`LPWG_IRQ_MICROTICK] &&
            state_reg.cfg.wdog_osc_powered &&
            state_reg.cfg.microtick_clk_en &&
            state_reg.cfg.microtick_started &&
            state_reg.cfg.wake_en0[`LPWG_IRQ_MICROTICK];
        src[LPWG_CAUSE_I2C] = deep_mode && I_IRQ_PEND[`LPWG_IRQ_I2C] &&
            state_reg.cfg.i2c_slave;
        src[LPWG_CAUSE_SPI] = deep_mode && I_IRQ_PEND[`LPWG_IRQ_SPI] &&
            state_reg.cfg.spi_slave;
        src[LPWG_CAUSE_USART] = deep_mode &&
            I_IRQ_PEND[`LPWG_IRQ_USART] &&
            (state_reg.cfg.usart_slave || state_reg.cfg.usart_32k);
    end

    // lowest code wins, resets first
    always_comb begin
        cause_sel = LPWG_CAUSE_NONE;
        for (int i = `LPWG_NCAUSE - 1; i > 0; i--) begin
            if (src[i]) begin
                cause_sel = lpwg_cause_type'(4'(i));
            end
        end
    end

    // valid entry request
    always_comb begin
        case (I_MODE_REQ)
            LPWG_SLEEP,
            LPWG_DEEP_SLEEP,
            LPWG_POWER_DOWN,
            LPWG_DEEP_PD: begin
                req_ok = 1'b1;
            end
            default: begin
                req_ok = 1'b0;
            end
        endcase
    end

    // mode sequencing
    always_comb begin
        state_next = state_reg;
        state_next.wake = 1'b0;
        state_next.reset_req = 1'b0;
        state_next.pin_act_prev = pin_act;
        case (state_reg.mode)
            LPWG_ACTIVE: begin
                if (I_ENTER && req_ok && !pin_act) begin
                    state_next.mode = lpwg_mode_type'(I_MODE_REQ);
                    state_next.cfg = cfg_in;
                end
                if (pin_act && !state_reg.pin_act_prev) begin
                    state_next.reset_req = 1'b1;
                end
            end
            LPWG_SLEEP,
            LPWG_DEEP_SLEEP,
            LPWG_POWER_DOWN,
            LPWG_DEEP_PD: begin
                if (cause_sel != LPWG_CAUSE_NONE) begin
                    state_next.mode = LPWG_ACTIVE;
                    state_next.wake = 1'b1;
                    state_next.cause = cause_sel;
                    state_next.reset_req = dpd_mode ||
                        (cause_sel == LPWG_CAUSE_RESET_PIN) ||
                        (cause_sel == LPWG_CAUSE_BROWNOUT_RST) ||
                        (cause_sel == LPWG_CAUSE_WDOG_RST);
                end
            end
            default: begin
                state_next.mode = LPWG_ACTIVE;
            end
        endcase
        state_next.core_clk_en = (state_next.mode == LPWG_ACTIVE);
        state_next.periph_clk_en = (state_next.mode == LPWG_ACTIVE) ||
                                   (state_next.mode == LPWG_SLEEP);
    end

    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state_reg <= '0;
            state_reg.core_clk_en <= 1'b1;
            state_reg.periph_clk_en <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign O_MODE = state_reg.mode;
    assign O_WAKE = state_reg.wake;
    assign O_WAKE_CAUSE = state_reg.cause;
    assign O_RESET_REQ = state_reg.reset_req;
    assign O_CORE_CLK_EN = state_reg.core_clk_en;
    assign O_PERIPH_CLK_EN = state_reg.periph_clk_en;

endmodule : lpwg_top
